// file: pkg/pec_defines.svh
// constants for the phy error counters and prbs self-test block
`ifndef PEC_DEFINES_SVH
`define PEC_DEFINES_SVH
`define PEC_ADDR_FALSE_CARRIER 5'h14
`define PEC_ADDR_RX_ERROR 5'h15
`define PEC_ADDR_SELFTEST 5'h16
`define PEC_FC_MAX 16'h00FF
`define PEC_RX_MAX 16'h00FF
`define PEC_HALF_FULL 16'h007F
`define PEC_SELFTEST_RESET 16'h0100
`define PEC_BIT_WRAP_MODE 14
`define PEC_BIT_CFG_HI 13
`define PEC_BIT_CFG_LO 12
`define PEC_BIT_LOCKED 11
`define PEC_BIT_LOST_LOCK 10
`define PEC_BIT_GEN_STATUS 9
`define PEC_BIT_POWER_MODE 8
`define PEC_LOCK_GOOD 4'hF
`define PEC_BIST_ERR_MAX 8'hFF
`define PEC_PRBS_SEED 7'h7F
`endif

// file: pkg/pec_pkg.sv
// types shared by the phy error counters and prbs self-test block
package pec_pkg;
	typedef enum logic [1:0] {
		PEC_CFG_OFF = 2'h0,
		PEC_CFG_SINGLE = 2'h1,
		PEC_CFG_CHECK = 2'h2,
		PEC_CFG_BOTH = 2'h3
	} pec_prbs_cfg_t;
	typedef enum logic [2:0] {
		PEC_GEN_IDLE = 3'b001,
		PEC_GEN_SEND = 3'b010,
		PEC_GEN_DONE = 3'b100
	} pec_gen_state_t;
endpackage : pec_pkg

// file: verilog/pec_sat_counter.sv
// saturating clear-on-read event counter with half-full crossing pulse
`timescale 1ns/1ns
`include "pec_defines.svh"
module pec_sat_counter
	import pec_pkg::*;
#(
	parameter logic [15:0] MAX = 16'h00FF
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// control
	input wire logic inc,
	input wire logic clr,
	// status
	output logic [15:0] count,
	output logic hf_pulse
);
	typedef struct packed {
		logic [15:0] cnt;
		logic hf;
	} pec_cnt_state_t;

	pec_cnt_state_t st_reg;
	pec_cnt_state_t st_next;

	always_comb begin
		logic [15:0] base;
		base = 16'h0000;
		st_next = st_reg;
		// an event in the clearing cycle survives as a count of one
		base = clr ? 16'h0000 : st_reg.cnt;
		st_next.hf = 1'b0;
		if (inc && base != MAX) begin
			st_next.cnt = base + 16'h0001;
			// counts only step by one, so equality marks the single crossing
			st_next.hf = (base == `PEC_HALF_FULL);
		end else begin
			st_next.cnt = base;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign count = st_reg.cnt;
	assign hf_pulse = st_reg.hf;

	property p_cnt_saturates;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_reg.cnt == MAX && !clr) |=> (st_reg.cnt == MAX);
	endproperty
	a_cnt_saturates: assert property (p_cnt_saturates) else $error("counter left max");
endmodule : pec_sat_counter

// file: verilog/pec_prbs.sv
// prbs generator and checker with bist error counter
`timescale 1ns/1ns
`include "pec_defines.svh"
module pec_prbs
	import pec_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// configuration
	input wire logic [1:0] cfg,
	input wire logic wrap_mode,
	input wire logic [15:0] pkt_len,
	input wire logic [7:0] pkt_const,
	// line side
	input wire logic rx_bit,
	input wire logic rx_bit_vld,
	output logic tx_bit,
	output logic tx_bit_vld,
	// status
	output logic gen_active,
	output logic locked,
	output logic lost_lock_pulse,
	output logic [7:0] bist_err_count,
	output logic bist_wrap_pulse
);
	typedef struct packed {
		pec_gen_state_t gst;
		logic [6:0] glfsr;
		logic [15:0] gcnt;
		logic txb;
		logic txv;
		logic [6:0] clfsr;
		logic [3:0] good;
		logic lock;
		logic miss;
		logic lost;
		logic [7:0] err;
		logic wrap;
	} pec_prbs_state_t;

	pec_prbs_state_t st_reg;
	pec_prbs_state_t st_next;

	function automatic logic prbs_fb(input logic [6:0] l);
		prbs_fb = l[6] ^ l[5];
	endfunction : prbs_fb

	always_comb begin
		logic match;
		match = 1'b0;
		st_next = st_reg;
		st_next.txv = 1'b0;
		st_next.lost = 1'b0;
		st_next.wrap = 1'b0;
		case (st_reg.gst)
			PEC_GEN_IDLE: begin
				st_next.gcnt = 16'h0000;
				if (cfg[0] && pkt_len != 16'h0000) begin
					st_next.gst = PEC_GEN_SEND;
				end
			end
			PEC_GEN_SEND: begin
				// a bit still in flight when the mode leaves send is not marked valid
				st_next.txv = cfg[0];
				if (cfg == PEC_CFG_SINGLE) begin
					st_next.txb = pkt_const[st_reg.gcnt[2:0]];
				end else begin
					st_next.txb = prbs_fb(st_reg.glfsr);
					st_next.glfsr = {st_reg.glfsr[5:0], prbs_fb(st_reg.glfsr)};
				end
				st_next.gcnt = st_reg.gcnt + 16'h0001;
				if (!cfg[0]) begin
					st_next.gst = PEC_GEN_IDLE;
				end else if (st_reg.gcnt == pkt_len - 16'h0001) begin
					st_next.gcnt = 16'h0000;
					// continuous mode starts the next packet at once
					st_next.gst = (cfg == PEC_CFG_BOTH) ? PEC_GEN_SEND : PEC_GEN_DONE;
				end
			end
			PEC_GEN_DONE: begin
				// single packet is re-armed only by leaving the mode
				if (cfg != PEC_CFG_SINGLE) begin
					st_next.gst = PEC_GEN_IDLE;
				end
			end
			default: begin
				st_next.gst = PEC_GEN_IDLE;
			end
		endcase
		if (!cfg[1]) begin
			st_next.clfsr = `PEC_PRBS_SEED;
			st_next.good = 4'h0;
			st_next.lock = 1'b0;
			st_next.miss = 1'b0;
			st_next.err = 8'h00;
		end else if (rx_bit_vld) begin
			match = (rx_bit == prbs_fb(st_reg.clfsr));
			st_next.clfsr = {st_reg.clfsr[5:0], rx_bit};
			if (!st_reg.lock) begin
				// a stale miss would drop a fresh lock on its first error
				st_next.miss = 1'b0;
				st_next.good = match ? st_reg.good + 4'h1 : 4'h0;
				st_next.lock = (st_reg.good == `PEC_LOCK_GOOD - 4'h1) && match;
			end else begin
				st_next.miss = !match;
				if (!match && st_reg.miss) begin
					st_next.lock = 1'b0;
					st_next.good = 4'h0;
					st_next.lost = 1'b1;
				end
				if (!match) begin
					if (st_reg.err != `PEC_BIST_ERR_MAX) begin
						st_next.err = st_reg.err + 8'h01;
					end else if (wrap_mode) begin
						st_next.err = 8'h00;
						st_next.wrap = 1'b1;
					end // single mode holds at max
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '{gst: PEC_GEN_IDLE, glfsr: `PEC_PRBS_SEED, clfsr: `PEC_PRBS_SEED,
				default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign tx_bit = st_reg.txb;
	assign tx_bit_vld = st_reg.txv;
	assign gen_active = (st_reg.gst == PEC_GEN_SEND);
	assign locked = st_reg.lock;
	assign lost_lock_pulse = st_reg.lost;
	assign bist_err_count = st_reg.err;
	assign bist_wrap_pulse = st_reg.wrap;

	property p_single_holds;
		@(posedge ref_clk) disable iff (!arst_n)
		(cfg[1] && !wrap_mode && st_reg.err == `PEC_BIST_ERR_MAX) |=> (st_reg.err == 8'hFF);
	endproperty
	a_single_holds: assert property (p_single_holds) else $error("single mode wrapped");
endmodule : pec_prbs

// file: verilog/pec_top.sv
// phy diagnostic counters and prbs self-test control with register port
`timescale 1ns/1ns
`include "pec_defines.svh"
module pec_top
	import pec_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port from the management frame decoder
	input wire logic [4:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// receive path events
	input wire logic false_carrier_evt,
	input wire logic rx_err_evt,
	input wire logic rx_dv,
	input wire logic mii_loopback,
	// interrupt control
	input wire logic fc_hf_int_en,
	input wire logic rxerr_hf_int_en,
	output logic fc_hf_evt,
	output logic rxerr_hf_evt,
	output logic fc_hf_irq,
	output logic rxerr_hf_irq,
	// packet format
	input wire logic [15:0] pkt_len,
	input wire logic [7:0] pkt_const,
	// self-test bit streams
	input wire logic rx_bit,
	input wire logic rx_bit_vld,
	output logic tx_bit,
	output logic tx_bit_vld,
	output logic [7:0] bist_err_count,
	output logic bist_wrap_pulse
);
	typedef struct packed {
		logic [15:0] rdata;
		logic rvalid;
		logic wrap_mode;
		logic [1:0] cfg;
		logic lost;
	} pec_top_state_t;

	pec_top_state_t st_reg;
	pec_top_state_t st_next;

	logic [15:0] fc_count;
	logic [15:0] rx_count;
	logic fc_hf;
	logic rx_hf;
	logic rd_fc;
	logic rd_rx;
	logic rd_st;
	logic wr_st;
	logic rx_inc;
	logic locked;
	logic lost_pulse;
	logic gen_active;
	logic [15:0] selftest_view;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		hit = (a == off);
	endfunction : hit

	always_comb begin
		rd_fc = 1'b0;
		rd_rx = 1'b0;
		rd_st = 1'b0;
		if (hit(reg_addr, `PEC_ADDR_FALSE_CARRIER)) begin
			rd_fc = reg_rd;
		end else if (hit(reg_addr, `PEC_ADDR_RX_ERROR)) begin
			rd_rx = reg_rd;
		end else if (hit(reg_addr, `PEC_ADDR_SELFTEST)) begin
			rd_st = reg_rd;
		end
	end

	assign wr_st = reg_wr && hit(reg_addr, `PEC_ADDR_SELFTEST);
	// loopback traffic is self-made, so its symbol errors are not line errors
	assign rx_inc = rx_err_evt && rx_dv && !mii_loopback;

	pec_sat_counter #(
		.MAX(`PEC_FC_MAX)
	) u_fc_cnt (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.inc(false_carrier_evt),
		.clr(rd_fc),
		.count(fc_count),
		.hf_pulse(fc_hf)
	);

	pec_sat_counter #(
		.MAX(`PEC_RX_MAX)
	) u_rx_cnt (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.inc(rx_inc),
		.clr(rd_rx),
		.count(rx_count),
		.hf_pulse(rx_hf)
	);

	pec_prbs u_prbs (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.cfg(st_reg.cfg),
		.wrap_mode(st_reg.wrap_mode),
		.pkt_len(pkt_len),
		.pkt_const(pkt_const),
		.rx_bit(rx_bit),
		.rx_bit_vld(rx_bit_vld),
		.tx_bit(tx_bit),
		.tx_bit_vld(tx_bit_vld),
		.gen_active(gen_active),
		.locked(locked),
		.lost_lock_pulse(lost_pulse),
		.bist_err_count(bist_err_count),
		.bist_wrap_pulse(bist_wrap_pulse)
	);

	always_comb begin
		selftest_view = `PEC_SELFTEST_RESET;
		selftest_view[`PEC_BIT_WRAP_MODE] = st_reg.wrap_mode;
		selftest_view[`PEC_BIT_CFG_HI] = st_reg.cfg[1];
		selftest_view[`PEC_BIT_CFG_LO] = st_reg.cfg[0];
		selftest_view[`PEC_BIT_LOCKED] = locked;
		selftest_view[`PEC_BIT_LOST_LOCK] = st_reg.lost;
		selftest_view[`PEC_BIT_GEN_STATUS] = gen_active;
	end

	always_comb begin
		st_next = st_reg;
		st_next.rvalid = reg_rd;
		if (rd_fc) begin
			st_next.rdata = fc_count;
		end else if (rd_rx) begin
			st_next.rdata = rx_count;
		end else if (rd_st) begin
			st_next.rdata = selftest_view;
		end else if (reg_rd) begin
			// other addresses belong to neighbouring blocks
			st_next.rdata = 16'h0000;
		end
		if (wr_st) begin
			st_next.wrap_mode = reg_wdata[`PEC_BIT_WRAP_MODE];
			st_next.cfg = reg_wdata[`PEC_BIT_CFG_HI:`PEC_BIT_CFG_LO];
		end
		// latched loss clears on read, but a new loss wins over the clear
		if (lost_pulse) begin
			st_next.lost = 1'b1;
		end else if (rd_st) begin
			st_next.lost = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign reg_rvalid = st_reg.rvalid;
	assign fc_hf_evt = fc_hf;
	assign rxerr_hf_evt = rx_hf;
	// pending status is kept outside; only the pin path is gated here
	assign fc_hf_irq = fc_hf && fc_hf_int_en;
	assign rxerr_hf_irq = rx_hf && rxerr_hf_int_en;

	sequence s_fc_bump;
		false_carrier_evt && !rd_fc && fc_count < `PEC_FC_MAX;
	endsequence

	sequence s_fc_read;
		reg_rvalid && reg_rdata == $past(fc_count);
	endsequence

	property p_fc_inc;
		@(posedge ref_clk) disable iff (!arst_n)
		s_fc_bump |=> (fc_count == $past(fc_count) + 16'h0001);
	endproperty
	a_fc_inc: assert property (p_fc_inc) else $error("false carrier count did not step");

	property p_fc_sat;
		@(posedge ref_clk) disable iff (!arst_n)
		(fc_count == 16'h00FF && !rd_fc) |=> (fc_count == 16'h00FF);
	endproperty
	a_fc_sat: assert property (p_fc_sat) else $error("false carrier count wrapped");

	property p_fc_hf;
		@(posedge ref_clk) disable iff (!arst_n)
		(fc_count == 16'h007F && false_carrier_evt && !rd_fc) |=> fc_hf_evt;
	endproperty
	a_fc_hf: assert property (p_fc_hf) else $error("false carrier half-full missed");

	property p_read_clear;
		@(posedge ref_clk) disable iff (!arst_n)
		(rd_fc && !false_carrier_evt) |-> ##1 (reg_rdata == $past(fc_count) && fc_count == 16'h0000);
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("clear on read failed");

	property p_rx_loopback;
		@(posedge ref_clk) disable iff (!arst_n)
		(mii_loopback && !rd_rx) |=> (rx_count == $past(rx_count));
	endproperty
	a_rx_loopback: assert property (p_rx_loopback) else $error("counted in loopback");

	property p_rx_inc;
		@(posedge ref_clk) disable iff (!arst_n)
		(rx_err_evt && rx_dv && !mii_loopback && !rd_rx && rx_count < `PEC_RX_MAX)
		|=> (rx_count == $past(rx_count) + 16'h0001);
	endproperty
	a_rx_inc: assert property (p_rx_inc) else $error("receive error not counted");

	property p_rx_sat;
		@(posedge ref_clk) disable iff (!arst_n)
		(rx_count == 16'h00FF && !rd_rx) |=> (rx_count == 16'h00FF);
	endproperty
	a_rx_sat: assert property (p_rx_sat) else $error("receive error count passed max");

	property p_rx_hf;
		@(posedge ref_clk) disable iff (!arst_n)
		(rx_count == 16'h007F && rx_inc && !rd_rx) |=> (rxerr_hf_evt ##1 !rxerr_hf_evt);
	endproperty
	a_rx_hf: assert property (p_rx_hf) else $error("receive error half-full wrong");

	property p_irq_gate;
		@(posedge ref_clk) disable iff (!arst_n)
		(fc_hf_irq |-> fc_hf_int_en) and (rxerr_hf_irq |-> rxerr_hf_int_en);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");

	property p_clear_keeps_event;
		@(posedge ref_clk) disable iff (!arst_n)
		(rd_fc && false_carrier_evt) |=> (fc_count == 16'h0001);
	endproperty
	a_clear_keeps_event: assert property (p_clear_keeps_event) else $error("event lost");

	property p_hf_once;
		@(posedge ref_clk) disable iff (!arst_n)
		fc_hf_evt |-> (fc_count == 16'h0080);
	endproperty
	a_hf_once: assert property (p_hf_once) else $error("half-full event off crossing");

	property p_lost_sticky;
		@(posedge ref_clk) disable iff (!arst_n)
		lost_pulse |=> (st_reg.lost [*1] ##0 1'b1);
	endproperty
	a_lost_sticky: assert property (p_lost_sticky) else $error("sync loss not latched");

	property p_off_idle;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_reg.cfg == PEC_CFG_OFF) [*3] |-> (!tx_bit_vld && !locked);
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("self-test active while off");

	property p_read_valid;
		@(posedge ref_clk) disable iff (!arst_n)
		rd_fc |=> s_fc_read;
	endproperty
	a_read_valid: assert property (p_read_valid) else $error("read answer missing");
endmodule : pec_top

// file: testbench/pec_host_model.sv
// management host model driving the strobe register port
`timescale 1ns/1ns
module pec_host_model (
	// clock
	input wire logic ref_clk,
	// register port
	output logic [4:0] reg_addr,
	output logic reg_rd,
	output logic reg_wr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_addr = 5'h00;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
	end
	// callers enter at a falling edge; a strobe lasts exactly one cycle
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		d = 16'hXXXX;
		reg_addr = a;
		reg_rd = 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(negedge ref_clk);
			reg_rd = 1'b0;
			if (reg_rvalid === 1'b1) begin
				d = reg_rdata;
				break;
			end
		end
		// released address must not look like a valid request
		reg_addr = ~a;
		@(negedge ref_clk);
	endtask : rd
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~v;
		@(negedge ref_clk);
	endtask : wr
endmodule : pec_host_model

// file: testbench/phy_error_counters_and_prbs_bist_tb.sv
// self-checking bench for the error counters and prbs self-test block
`timescale 1ns/1ns
module phy_error_counters_and_prbs_bist_tb;
	logic ref_clk, arst_n, reg_rd, reg_wr, reg_rvalid, false_carrier_evt, rx_err_evt;
	logic rx_dv, mii_loopback, fc_hf_int_en, rxerr_hf_int_en, fc_hf_evt, rxerr_hf_evt;
	logic fc_hf_irq, rxerr_hf_irq, rx_bit, rx_bit_vld, tx_bit, tx_bit_vld, bist_wrap_pulse;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, pkt_len, d, w;
	logic [7:0] pkt_const, bist_err_count;
	logic [6:0] prbs = 7'h7F;
	logic txq[$];
	int error_cnt = 0;
	int checks = 0;
	int fc_hf_n = 0, fc_irq_n = 0, rx_hf_n = 0, rx_irq_n = 0, wrap_n = 0;

	pec_top DUT (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.false_carrier_evt(false_carrier_evt), .rx_err_evt(rx_err_evt), .rx_dv(rx_dv),
		.mii_loopback(mii_loopback), .fc_hf_int_en(fc_hf_int_en),
		.rxerr_hf_int_en(rxerr_hf_int_en), .fc_hf_evt(fc_hf_evt), .rxerr_hf_evt(rxerr_hf_evt),
		.fc_hf_irq(fc_hf_irq), .rxerr_hf_irq(rxerr_hf_irq), .pkt_len(pkt_len),
		.pkt_const(pkt_const), .rx_bit(rx_bit), .rx_bit_vld(rx_bit_vld), .tx_bit(tx_bit),
		.tx_bit_vld(tx_bit_vld), .bist_err_count(bist_err_count),
		.bist_wrap_pulse(bist_wrap_pulse));

	pec_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// pulse counts tell a single firing from a repeated one
	always @(posedge ref_clk) begin
		fc_hf_n <= fc_hf_n + (fc_hf_evt === 1'b1);
		fc_irq_n <= fc_irq_n + (fc_hf_irq === 1'b1);
		rx_hf_n <= rx_hf_n + (rxerr_hf_evt === 1'b1);
		rx_irq_n <= rx_irq_n + (rxerr_hf_irq === 1'b1);
		wrap_n <= wrap_n + (bist_wrap_pulse === 1'b1);
		if (tx_bit_vld === 1'b1) begin
			txq.push_back(tx_bit);
		end
	end

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	task automatic pulse(input logic fc, input int n);
		repeat (n) begin
			false_carrier_evt = fc;
			rx_err_evt = !fc;
			@(negedge ref_clk);
			false_carrier_evt = 1'b0;
			rx_err_evt = 1'b0;
			@(negedge ref_clk);
		end
	endtask : pulse

	// prbs7 stream; every per-th bit from the first is inverted, none when per is 0
	task automatic feed(input int n, input int per);
		logic b;
		for (int i = 0; i < n; i++) begin
			b = prbs[6] ^ prbs[5];
			prbs = {prbs[5:0], b};
			rx_bit = b ^ (per != 0 && i % per == 0);
			rx_bit_vld = 1'b1;
			@(negedge ref_clk);
		end
		rx_bit_vld = 1'b0;
	endtask : feed

	initial begin
		#(50 * 40000);
		error_cnt++;
		give_verdict();
	end

	initial begin
		arst_n = 1'b0;
		false_carrier_evt = 1'b0;
		rx_err_evt = 1'b0;
		rx_dv = 1'b1;
		mii_loopback = 1'b0;
		fc_hf_int_en = 1'b1;
		rxerr_hf_int_en = 1'b0;
		pkt_len = 16'h0010;
		pkt_const = 8'hA5;
		rx_bit = 1'b0;
		rx_bit_vld = 1'b0;
		repeat (12) @(negedge ref_clk);
		arst_n = 1'b1;
		@(negedge ref_clk);
		host.rd(5'h14, d);
		chk("fc reset", d, 16'h0000);
		host.rd(5'h15, d);
		chk("rx reset", d, 16'h0000);
		host.rd(5'h16, d);
		chk("selftest reset", d, 16'h0100);
		host.wr(5'h14, 16'h0033);
		host.rd(5'h14, d);
		chk("fc write refused", d, 16'h0000);
		host.rd(5'h10, d);
		chk("unmapped read", d, 16'h0000);
		// false carrier: threshold, saturation, clear, refire
		pulse(1'b1, 127);
		chk("fc hf early", 16'(fc_hf_n), 16'h0000);
		pulse(1'b1, 1);
		chk("fc hf crossing", 16'(fc_hf_n), 16'h0001);
		chk("fc irq enabled", 16'(fc_irq_n), 16'h0001);
		pulse(1'b1, 140);
		chk("fc hf once", 16'(fc_hf_n), 16'h0001);
		host.rd(5'h14, d);
		chk("fc saturated", d, 16'h00FF);
		host.rd(5'h14, d);
		chk("fc cleared", d, 16'h0000);
		fc_hf_int_en = 1'b0;
		pulse(1'b1, 130);
		chk("fc hf after clear", 16'(fc_hf_n), 16'h0002);
		chk("fc irq masked", 16'(fc_irq_n), 16'h0001);
		host.rd(5'h14, d);
		chk("fc count", d, 16'h0082);
		// event in the same cycle as the clearing read survives as one
		fork
			host.rd(5'h14, d);
			begin
				false_carrier_evt = 1'b1;
				@(negedge ref_clk);
				false_carrier_evt = 1'b0;
			end
		join
		chk("fc read during event", d, 16'h0000);
		host.rd(5'h14, d);
		chk("fc kept event", d, 16'h0001);
		// receive errors: gating by data valid and loopback
		rx_dv = 1'b0;
		pulse(1'b0, 3);
		rx_dv = 1'b1;
		mii_loopback = 1'b1;
		pulse(1'b0, 3);
		mii_loopback = 1'b0;
		pulse(1'b0, 5);
		host.rd(5'h15, d);
		chk("rx gated count", d, 16'h0005);
		pulse(1'b0, 300);
		chk("rx hf once", 16'(rx_hf_n), 16'h0001);
		chk("rx irq masked", 16'(rx_irq_n), 16'h0000);
		host.rd(5'h15, d);
		chk("rx saturated", d, 16'h00FF);
		rxerr_hf_int_en = 1'b1;
		pulse(1'b0, 128);
		chk("rx irq enabled", 16'(rx_irq_n), 16'h0001);
		// self-test configurations
		host.wr(5'h16, 16'h4000);
		txq.delete();
		repeat (20) @(negedge ref_clk);
		host.rd(5'h16, d);
		chk("cfg off readback", d, 16'h4100);
		chk("cfg off no tx", 16'(txq.size()), 16'h0000);
		host.wr(5'h16, 16'h1000);
		repeat (40) @(negedge ref_clk);
		chk("single pkt length", 16'(txq.size()), 16'h0010);
		for (int i = 0; i < 16; i++) begin
			w[i] = txq[i];
		end
		chk("single pkt data", w, 16'hA5A5);
		host.rd(5'h16, d);
		chk("single done", d, 16'h1100);
		host.wr(5'h16, 16'h3000);
		txq.delete();
		repeat (30) @(negedge ref_clk);
		chk("continuous tx", 16'(txq.size() >= 26), 16'h0001);
		host.rd(5'h16, d);
		chk("continuous status", d & 16'hF300, 16'h3300);
		host.wr(5'h16, 16'h2000);
		txq.delete();
		feed(30, 1'b0);
		host.rd(5'h16, d);
		chk("checker locked", d, 16'h2900);
		chk("checker only no tx", 16'(txq.size()), 16'h0000);
		feed(2, 1'b1);
		repeat (3) @(negedge ref_clk);
		host.rd(5'h16, d);
		chk("sync lost", d, 16'h2500);
		host.rd(5'h16, d);
		chk("sync loss cleared", d, 16'h2100);
		chk("bist count", 16'(bist_err_count), 16'h0002);
		// a lone bad bit costs three mismatches, then 15 good bits relock: 23 bits a round
		feed(22, 0);
		feed(23 * 85, 23);
		chk("bist single holds", 16'(bist_err_count), 16'h00FF);
		chk("bist no wrap", 16'(wrap_n), 16'h0000);
		host.wr(5'h16, 16'h6000);
		feed(23, 23);
		chk("bist wrap count", 16'(bist_err_count), 16'h0002);
		chk("bist wrap pulse", 16'(wrap_n), 16'h0001);
		host.rd(5'h16, d);
		chk("relocked after wrap", d, 16'h6D00);
		give_verdict();
	end
endmodule : phy_error_counters_and_prbs_bist_tb
